// File: design/pcg_pkg.sv
package pcg_pkg;
	localparam int unsigned PCG_W = 8;
	localparam logic [1:0] PCG_OFF_PIN = 2'h0;
	localparam logic [1:0] PCG_OFF_LATCH = 2'h1;
	localparam logic [1:0] PCG_OFF_DIR = 2'h2;
	localparam logic [1:0] PCG_OFF_CFG = 2'h3;
	// Bits with a latch and direction flop: 0,1,2,6,7
	localparam logic [7:0] PCG_IMPL_MASK = 8'hc7;
	// Bits that exist as pins: all but bit 3
	localparam logic [7:0] PCG_PIN_MASK = 8'hf7;
	localparam logic [7:0] PCG_LATCH_RST = 8'h00;
	localparam logic [7:0] PCG_DIR_RST = 8'hc7;
	localparam logic [3:0] PCG_CFG_RST = 4'h2;
	localparam int unsigned PCG_CFG_USB_MODULE_ENABLE = 0;
	localparam int unsigned PCG_CFG_XCVR_DIS = 1;
	localparam int unsigned PCG_CFG_T1OSC = 2;
	localparam int unsigned PCG_CFG_OE_BIT = 1;
	localparam int unsigned PCG_CFG_CCP_PIN = 2;
	localparam int unsigned PCG_TX_PIN = 6;
	localparam int unsigned PCG_RX_PIN = 7;
	localparam int unsigned PCG_DM_PIN = 4;
	localparam int unsigned PCG_DP_PIN = 5;
endpackage : pcg_pkg

// File: design/pcg_ovr_if.sv
`timescale 1ns/10ps
interface pcg_ovr_if;
	logic [7:0] ovr_en;
	logic [7:0] ovr_oe;
	logic [7:0] ovr_out;
	modport src (output ovr_en, output ovr_oe, output ovr_out);
	modport dst (input ovr_en, input ovr_oe, input ovr_out);
endinterface : pcg_ovr_if

// File: design/pcg_ovr_mux.sv
`timescale 1ns/10ps
module pcg_ovr_mux
	import pcg_pkg::*;
(
	input  wire logic [7:0] dir_in,
	input  wire logic       usb_en_in,
	input  wire logic       xcvr_dis_in,
	input  wire logic       t1osc_en_in,
	input  wire logic       ccp_out_en_in,
	input  wire logic       ccp_out_in,
	input  wire logic       ser_tx_en_in,
	input  wire logic       ser_tx_in,
	input  wire logic       usb_oe_n_in,
	input  wire logic       usb_dm_out_in,
	input  wire logic       usb_dp_out_in,
	input  wire logic       usb_drive_in,
	input  wire logic       xcvr_oe_n_in,
	pcg_ovr_if.src          ovr
);
	logic ext_xcvr;
	logic int_xcvr;
	assign ext_xcvr = usb_en_in & xcvr_dis_in;
	assign int_xcvr = usb_en_in & ~xcvr_dis_in;
	always_comb begin
		ovr.ovr_en = 8'h00;
		ovr.ovr_oe = 8'h00;
		ovr.ovr_out = 8'h00;
		if (t1osc_en_in) begin
			// Oscillator pins go analog: digital driver off
			ovr.ovr_en[1:0] = 2'h3;
		end else if (ext_xcvr) begin
			// Transceiver enable on bit 1 as the pin table places it
			ovr.ovr_en[PCG_CFG_OE_BIT] = 1'b1;
			ovr.ovr_oe[PCG_CFG_OE_BIT] = 1'b1;
			ovr.ovr_out[PCG_CFG_OE_BIT] = xcvr_oe_n_in;
		end
		if (ccp_out_en_in && !dir_in[PCG_CFG_CCP_PIN]) begin
			ovr.ovr_en[PCG_CFG_CCP_PIN] = 1'b1;
			ovr.ovr_oe[PCG_CFG_CCP_PIN] = 1'b1;
			ovr.ovr_out[PCG_CFG_CCP_PIN] = ccp_out_in;
		end
		if (ser_tx_en_in && !dir_in[PCG_TX_PIN]) begin
			// Serial transmit or sync clock beats latch data
			ovr.ovr_en[PCG_TX_PIN] = 1'b1;
			ovr.ovr_oe[PCG_TX_PIN] = 1'b1;
			ovr.ovr_out[PCG_TX_PIN] = ser_tx_in;
		end
		if (int_xcvr) begin
			// USB data lines follow the module's current operation
			ovr.ovr_en[PCG_DP_PIN:PCG_DM_PIN] = 2'h3;
			ovr.ovr_oe[PCG_DP_PIN:PCG_DM_PIN] = {2{usb_drive_in & ~usb_oe_n_in}};
			ovr.ovr_out[PCG_DM_PIN] = usb_dm_out_in;
			ovr.ovr_out[PCG_DP_PIN] = usb_dp_out_in;
		end
	end
endmodule : pcg_ovr_mux

// File: design/pcg_port.sv
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - Direction one: pin driver released, input
// - Direction zero: pin driven from latch
// - Seven pins; bit three absent
// - Latch register reads back latch, not pins
// - USB pins: no direction; inputs unless the internal transceiver drives them
// - External transceiver: USB pins stay inputs
// - Internal transceiver: USB sets pin direction
// - External transceiver drives output enable pin unless timer oscillator on
// - Reset: all pins inputs, USB pins included
// - USB pin input only when USB off
// - Direction reads stored value despite overrides
// - Oscillator and USB overrides force pin direction; compare and serial need direction zero
// - Bit two: compare output or capture input
// - Bit six carries synchronous serial clock
// - Timer oscillator disables digital bits zero, one
// - Non-USB pins use Schmitt inputs
module pcg_port
	import pcg_pkg::*;
(
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic       clk_en_in,
	input  wire logic [1:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	input  wire logic [7:0] pin_in,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe_out,
	input  wire logic       ccp_out_en_in,
	input  wire logic       ccp_out_in,
	input  wire logic       ser_tx_en_in,
	input  wire logic       ser_tx_in,
	input  wire logic       usb_oe_n_in,
	input  wire logic       usb_dm_out_in,
	input  wire logic       usb_dp_out_in,
	input  wire logic       usb_drive_in,
	input  wire logic       xcvr_oe_n_in,
	output logic      [7:0] pin_sync_out,
	output logic            ext_xcvr_minus_in_out,
	output logic            ext_xcvr_plus_in_out,
	output logic            usb_module_enable_out,
	output logic            timer1_osc_en_out
);
	logic [7:0] latch_q, latch_d;
	logic [7:0] dir_q, dir_d;
	logic [3:0] cfg_q, cfg_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] sync1_q, sync2_q;
	logic [7:0] pout_q, pout_d;
	logic [7:0] poe_q, poe_d;
	logic [7:0] read_view;
	logic       port_in_ok;
	pcg_ovr_if  ovr ();

	pcg_ovr_mux u_mux (
		.dir_in        (dir_q),
		.usb_en_in     (cfg_q[PCG_CFG_USB_MODULE_ENABLE]),
		.xcvr_dis_in   (cfg_q[PCG_CFG_XCVR_DIS]),
		.t1osc_en_in   (cfg_q[PCG_CFG_T1OSC]),
		.ccp_out_en_in (ccp_out_en_in),
		.ccp_out_in    (ccp_out_in),
		.ser_tx_en_in  (ser_tx_en_in),
		.ser_tx_in     (ser_tx_in),
		.usb_oe_n_in   (usb_oe_n_in),
		.usb_dm_out_in (usb_dm_out_in),
		.usb_dp_out_in (usb_dp_out_in),
		.usb_drive_in  (usb_drive_in),
		.xcvr_oe_n_in  (xcvr_oe_n_in),
		.ovr           (ovr)
	);

	// USB pins read as port inputs only with module off, on-chip xcvr off
	assign port_in_ok = ~cfg_q[PCG_CFG_USB_MODULE_ENABLE] & cfg_q[PCG_CFG_XCVR_DIS];

	always_comb begin
		read_view = sync2_q & PCG_PIN_MASK;
		if (!port_in_ok) begin
			read_view[PCG_DP_PIN:PCG_DM_PIN] = 2'h0;
		end
		if (cfg_q[PCG_CFG_T1OSC]) begin
			read_view[1:0] = 2'h0;
		end
	end

	// Register file
	always_comb begin
		latch_d = latch_q;
		dir_d = dir_q;
		cfg_d = cfg_q;
		rdata_d = 8'h00;
		if (wr_in) begin
			unique case (addr_in)
				PCG_OFF_PIN, PCG_OFF_LATCH: latch_d = wdata_in & PCG_IMPL_MASK;
				PCG_OFF_DIR: dir_d = wdata_in & PCG_IMPL_MASK;
				PCG_OFF_CFG: cfg_d = wdata_in[3:0];
			endcase
		end
		if (rd_in) begin
			unique case (addr_in)
				PCG_OFF_PIN: rdata_d = read_view;
				PCG_OFF_LATCH: rdata_d = latch_q;
				PCG_OFF_DIR: rdata_d = dir_q;
				PCG_OFF_CFG: rdata_d = {4'h0, cfg_q};
			endcase
		end
	end

	// Pin drive: override first, else direction and latch
	always_comb begin
		pout_d = 8'h00;
		poe_d = 8'h00;
		for (int i = 0; i < PCG_W; i++) begin
			if (ovr.ovr_en[i]) begin
				poe_d[i] = ovr.ovr_oe[i];
				pout_d[i] = ovr.ovr_out[i];
			end else if (PCG_IMPL_MASK[i]) begin
				poe_d[i] = ~dir_q[i];
				pout_d[i] = latch_q[i];
			end
		end
		// Bit 7 is never driven by serial receive; software keeps it input
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			latch_q <= PCG_LATCH_RST;
			dir_q <= PCG_DIR_RST;
			cfg_q <= PCG_CFG_RST;
			rdata_q <= 8'h00;
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
			pout_q <= 8'h00;
			poe_q <= 8'h00;
		end else if (clk_en_in) begin
			latch_q <= latch_d;
			dir_q <= dir_d;
			cfg_q <= cfg_d;
			rdata_q <= rdata_d;
			// Buffer type is a pad property; the core only synchronises
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			pout_q <= pout_d;
			poe_q <= poe_d;
		end
	end

	assign rdata_out = rdata_q;
	assign pin_out = pout_q;
	assign pin_oe_out = poe_q;
	assign pin_sync_out = sync2_q;
	assign ext_xcvr_minus_in_out = sync2_q[PCG_DM_PIN];
	assign ext_xcvr_plus_in_out = sync2_q[PCG_DP_PIN];
	assign usb_module_enable_out = cfg_q[PCG_CFG_USB_MODULE_ENABLE];
	assign timer1_osc_en_out = cfg_q[PCG_CFG_T1OSC];
endmodule : pcg_port

// File: verif/pcg_pads.sv
`timescale 1ns/10ps
// Released pins show what the far side puts there, never the last driven level
module pcg_pads (
	input  wire logic [7:0] drv_in,
	input  wire logic [7:0] oe_in,
	input  wire logic [7:0] far_in,
	output logic      [7:0] pad_out
);
	assign pad_out = (oe_in & drv_in) | (~oe_in & far_in);
endmodule : pcg_pads

// File: verif/pcg_port_assertions.sv
`timescale 1ns/10ps
module pcg_port_assertions
	import pcg_pkg::*;
(
	input wire logic       clk_sys_in,
	input wire logic       rst_n_in,
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_out,
	input wire logic       ccp_out_en_in,
	input wire logic       ccp_out_in,
	input wire logic       usb_module_enable_out,
	input wire logic       timer1_osc_en_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_wr(a);
		wr_in && addr_in == a;
	endsequence
	sequence s_wr_rd(a);
		s_wr(a) ##1 (rd_in && addr_in == a);
	endsequence
	property p_rst;
		$rose(rst_n_in) |-> pin_oe_out == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("pins driven after reset");
	property p_idle;
		!$past(rd_in) |-> rdata_out == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside read slot");
	property p_absent;
		pin_oe_out[3] == 1'b0;
	endproperty
	a_absent: assert property (p_absent) else $error("absent bit driven");
	property p_usb_in;
		!usb_module_enable_out && !$past(usb_module_enable_out) |-> pin_oe_out[5:4] == 2'h0;
	endproperty
	a_usb_in: assert property (p_usb_in) else $error("usb pins driven in port mode");
	property p_osc;
		timer1_osc_en_out && $past(timer1_osc_en_out) |-> pin_oe_out[1:0] == 2'h0;
	endproperty
	a_osc: assert property (p_osc) else $error("osc pins driven digitally");
	property p_ccp;
		$past(ccp_out_en_in) && pin_oe_out[2] |-> pin_out[2] == $past(ccp_out_in);
	endproperty
	a_ccp: assert property (p_ccp) else $error("compare output lost on bit 2");
	property p_dir;
		s_wr(2'h2) ##1 !wr_in |=> pin_oe_out[7] == !$past(wdata_in[7], 2);
	endproperty
	a_dir: assert property (p_dir) else $error("bit 7 drive not from direction");
	property p_rb_lat;
		s_wr_rd(2'h1) |=> rdata_out == ($past(wdata_in, 2) & PCG_IMPL_MASK);
	endproperty
	a_rb_lat: assert property (p_rb_lat) else $error("latch readback wrong");
	property p_rb_dir;
		s_wr_rd(2'h2) |=> rdata_out == ($past(wdata_in, 2) & PCG_IMPL_MASK);
	endproperty
	a_rb_dir: assert property (p_rb_dir) else $error("direction readback wrong");
endmodule : pcg_port_assertions
bind pcg_port pcg_port_assertions chk_i (.*);

// File: verif/pcg_port_tb.sv
`timescale 1ns/10ps
module pcg_port_tb;
	logic clk_sys_in = 1'h0, rst_n_in = 1'h0, clk_en_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0;
	logic ccp_out_en_in = 1'h0, ccp_out_in = 1'h0, ser_tx_en_in = 1'h0, ser_tx_in = 1'h0;
	logic usb_oe_n_in = 1'h1, usb_dm_out_in = 1'h0, usb_dp_out_in = 1'h0;
	logic usb_drive_in = 1'h0, xcvr_oe_n_in = 1'h0;
	logic [1:0] addr_in = 2'h0;
	logic [7:0] wdata_in = 8'h00, far = 8'hb0, rdata_out, pin_in, pin_out, pin_oe_out, pin_sync_out;
	logic ext_xcvr_minus_in_out, ext_xcvr_plus_in_out, usb_module_enable_out, timer1_osc_en_out;
	int bad_count = 0, compares = 0, cyc = 0;
	pcg_port uut (.*);
	pcg_pads pads (.drv_in(pin_out), .oe_in(pin_oe_out), .far_in(far), .pad_out(pin_in));
	always #4 clk_sys_in = ~clk_sys_in;
	task automatic chk(input string n, input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		wr_in <= 1'h1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'h0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		rd_in <= 1'h1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'h0;
		#1 chk("rdata", rdata_out, e);
		@(posedge clk_sys_in);
	endtask : rd
	// Pin drive lags a register write by two edges
	task automatic pins(input logic [7:0] eoe, eout, input string t);
		repeat (2) @(posedge clk_sys_in);
		#1 chk("pin_oe", pin_oe_out, eoe);
		chk("pin_out", pin_out & pin_oe_out, eout);
		@(posedge clk_sys_in);
		$display("test %s done", t);
	endtask : pins
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'h1;
		rd(2'h2, 8'hc7);
		rd(2'h1, 8'h00);
		rd(2'h3, 8'h02);
		pins(8'h00, 8'h00, "reset");
		wr(2'h1, 8'hff);
		rd(2'h1, 8'hc7);
		wr(2'h2, 8'h00);
		rd(2'h2, 8'h00);
		pins(8'hc7, 8'hc7, "drive");
		wr(2'h1, 8'h05);
		wr(2'h2, 8'h80);
		repeat (6) @(posedge clk_sys_in);
		rd(2'h0, 8'hb5);
		chk("pin_sync", pin_sync_out, 8'hb5);
		ccp_out_en_in <= 1'h1;
		ser_tx_en_in <= 1'h1;
		ser_tx_in <= 1'h1;
		pins(8'h47, 8'h41, "override");
		ccp_out_en_in <= 1'h0;
		ser_tx_en_in <= 1'h0;
		wr(2'h3, 8'h04);
		pins(8'h44, 8'h04, "osc");
		chk("osc_en", {7'h00, timer1_osc_en_out}, 8'h01);
		rd(2'h2, 8'h80);
		xcvr_oe_n_in <= 1'h1;
		wr(2'h3, 8'h03);
		pins(8'h47, 8'h07, "ext xcvr");
		chk("plus_in", {7'h00, ext_xcvr_plus_in_out}, 8'h01);
		chk("minus_in", {7'h00, ext_xcvr_minus_in_out}, 8'h01);
		chk("usb_en", {7'h00, usb_module_enable_out}, 8'h01);
		usb_drive_in <= 1'h1;
		usb_oe_n_in <= 1'h0;
		usb_dm_out_in <= 1'h1;
		wr(2'h3, 8'h01);
		pins(8'h77, 8'h15, "int xcvr");
		repeat (4) @(posedge clk_sys_in);
		rd(2'h0, 8'h85);
		final_report();
	end
endmodule : pcg_port_tb
